/* verilog/pmcs_regs.svh */
// Bit positions, source codes and transition counts for the power mode clock selector
`ifndef PMCS_REGS_SVH
`define PMCS_REGS_SVH

// Positions inside the oscillator control readback word
`define PMCS_IDLE_BIT       7
`define PMCS_PRI_FLAG_BIT   3
`define PMCS_SEL_HI         1
`define PMCS_SEL_LO         0
// Position of the secondary-active flag inside the secondary timer control word
`define PMCS_SEC_FLAG_BIT   6

// Source-select codes
`define PMCS_SEL_PRI        2'h0
`define PMCS_SEL_SEC        2'h1
`define PMCS_SEL_RSV        2'h2
`define PMCS_SEL_INT        2'h3

// Mode state codes
`define PMCS_MODE_RUN       2'h0
`define PMCS_MODE_IDLE      2'h1
`define PMCS_MODE_SLEEP     2'h2
`define PMCS_MODE_WAKE      2'h3

// Sequencer state codes
`define PMCS_SW_IDLE        2'h0
`define PMCS_SW_OLD         2'h1
`define PMCS_SW_NEW         2'h2

// Clock transition: edges of the old source, then edges of the new source
`define PMCS_OLD_EDGES      2'h2
`define PMCS_NEW_EDGES      2'h3

// Source driving the device after reset
`define PMCS_RESET_SRC      2'h0

// Readback word after reset: only the primary-active flag set
`define PMCS_CTRL_RESET     8'h08

`endif

/* verilog/pmcs_pkg.sv */
// Types shared by the power mode clock selector modules
`default_nettype none
`include "pmcs_regs.svh"

package pmcs_pkg;

    // Clock source as seen by the device clock mux
    typedef enum logic [1:0] {
        PMCS_SRC_PRI = `PMCS_SEL_PRI,
        PMCS_SRC_SEC = `PMCS_SEL_SEC,
        PMCS_SRC_INT = `PMCS_SEL_INT
    } pmcs_src_t;

    // Power-managed mode
    typedef enum logic [1:0] {
        PMCS_RUN   = `PMCS_MODE_RUN,
        PMCS_IDLE  = `PMCS_MODE_IDLE,
        PMCS_SLEEP = `PMCS_MODE_SLEEP,
        PMCS_WAKE  = `PMCS_MODE_WAKE
    } pmcs_mode_t;

    // Clock switch sequencer state
    typedef enum logic [1:0] {
        PMCS_SW_IDLE = `PMCS_SW_IDLE,
        PMCS_SW_OLD  = `PMCS_SW_OLD,
        PMCS_SW_NEW  = `PMCS_SW_NEW
    } pmcs_sw_state_t;

    // Index of a source in the tick and ready vectors
    function automatic logic [1:0] pmcs_src_index(input pmcs_src_t src);
        case (src)
            PMCS_SRC_PRI: pmcs_src_index = 2'h0;
            PMCS_SRC_SEC: pmcs_src_index = 2'h1;
            default:      pmcs_src_index = 2'h2;
        endcase
    endfunction

endpackage

`default_nettype wire

/* verilog/pmcs_switch_if.sv */
// Signals between the mode controller and the clock switch sequencer
`timescale 1ns/1ps
`default_nettype none

interface pmcs_switch_if;
    import pmcs_pkg::*;

    logic        start;
    pmcs_src_t   new_src;
    logic        load;
    pmcs_src_t   load_src;
    logic [2:0]  tick;
    pmcs_src_t   active_src;
    logic        busy;

    modport ctrl (output start, output new_src, output load, output load_src,
                  output tick, input active_src, input busy);
    modport seq  (input start, input new_src, input load, input load_src,
                  input tick, output active_src, output busy);
endinterface

`default_nettype wire

/* verilog/pmcs_switch_seq.sv */
// Clock switch sequencer: old-clock edges, then new-clock edges, then hand-over
`timescale 1ns/1ps
`default_nettype none

module pmcs_switch_seq
    import pmcs_pkg::*;
(
    input  wire logic   core_clk,
    input  wire logic   rst_n,
    pmcs_switch_if.seq  sw
);

    pmcs_sw_state_t state;
    pmcs_src_t      target;
    pmcs_src_t      active;
    logic [1:0]     cnt;
    logic           old_tick;
    logic           new_tick;

    assign old_tick      = sw.tick[pmcs_src_index(active)];
    assign new_tick      = sw.tick[pmcs_src_index(target)];
    assign sw.busy       = (state != PMCS_SW_IDLE);
    assign sw.active_src = active;

    ////////////////////////////////////////////////////////////////////////////
    // Sequencing; the device keeps the old source until the new one has ticked
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state  <= PMCS_SW_IDLE;
            target <= PMCS_SRC_PRI;
            active <= pmcs_src_t'(`PMCS_RESET_SRC);
            cnt    <= 2'h0;
        end else begin
            case (state)
                PMCS_SW_IDLE: begin
                    if (sw.load) begin
                        active <= sw.load_src;
                    end else if (sw.start) begin
                        target <= sw.new_src;
                        cnt    <= 2'h0;
                        state  <= PMCS_SW_OLD;
                    end
                end
                PMCS_SW_OLD: begin
                    if (old_tick) begin
                        if (cnt == `PMCS_OLD_EDGES - 2'h1) begin
                            cnt   <= 2'h0;
                            state <= PMCS_SW_NEW;
                        end else begin
                            cnt <= cnt + 2'h1;
                        end
                    end
                end
                PMCS_SW_NEW: begin
                    if (new_tick) begin
                        if (cnt == `PMCS_NEW_EDGES - 2'h1) begin
                            cnt    <= 2'h0;
                            active <= target;
                            state  <= PMCS_SW_IDLE;
                        end else begin
                            cnt <= cnt + 2'h1;
                        end
                    end
                end
                default: begin
                    state <= PMCS_SW_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence sw_begin;
        state == PMCS_SW_IDLE && !sw.load && sw.start;
    endsequence

    sequence sw_last_new;
        state == PMCS_SW_NEW && new_tick && cnt == 2'h2;
    endsequence

    switch_begin_a: assert property (sw_begin |=> state == PMCS_SW_OLD && cnt == 2'h0)
        else $error("switch did not begin on start");
    switch_done_a: assert property (sw_last_new |=> !sw.busy && active == $past(target))
        else $error("switch did not finish after third new edge");
    old_phase_a: assert property (state == PMCS_SW_OLD && old_tick && cnt == 2'h1
                                  |=> state == PMCS_SW_NEW && active == $past(active))
        else $error("old phase did not end after two edges");

endmodule

`default_nettype wire

/* verilog/pmcs_power_mode_ctrl.sv */
// Power mode controller: Run, Idle and Sleep clocking and source selection
//
// What this block does
// - Idle bit picks Idle or Sleep; 2-bit field picks source
// - Field 00 primary, 01 secondary, 11 internal
// - New field value starts a switch at once in Run or Idle if source ready and no switch busy
// - Only sleep instruction enters Sleep or Idle
// - Sleep stops CPU, peripherals and all sources
// - Idle stops CPU, peripherals follow selected source
// - Idle bit sampled at each sleep instruction
// - Switch takes two old, three new cycles
// - Flags show primary or secondary drives device
// - Run clocks both CPU and peripherals
// - Reset starts primary run, flag set; internal instead with two-speed start-up
// - Secondary select stops primary, swaps flags
`timescale 1ns/1ps
`default_nettype none

module pmcs_power_mode_ctrl
    import pmcs_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    input  wire logic        idle_on_sleep_select,
    input  wire logic [1:0]  clock_source_select,
    input  wire logic        sleep_exec,
    input  wire logic        wake_event,
    input  wire logic        two_speed_startup_en,
    input  wire logic        primary_osc_clk,
    input  wire logic        secondary_osc_clk,
    input  wire logic        internal_rc_clock,
    input  wire logic [2:0]  osc_ready,
    output logic             cpu_clk_en,
    output logic             periph_clk_en,
    output logic             primary_osc_en,
    output logic             secondary_osc_en,
    output logic             internal_osc_en,
    output logic [1:0]       device_clk_select,
    output logic             primary_clock_active_flag,
    output logic             secondary_clock_active_flag,
    output logic [7:0]       oscillator_control_reg
);

    pmcs_switch_if sw ();

    logic        rst_meta;
    logic        rst_n;
    logic [2:0]  osc_meta;
    logic [2:0]  osc_sync;
    logic [2:0]  osc_prev;
    logic [2:0]  rdy_meta;
    logic [2:0]  rdy_sync;
    pmcs_mode_t  mode;
    logic        started;
    logic        sleep_pend;
    logic        pend_idle;
    logic        take_sleep;
    logic        take_idle;
    pmcs_src_t   req_src;
    pmcs_src_t   pending_target;
    logic        pri_needed;
    logic        sec_needed;
    logic        int_needed;

    // Field decode; the unlisted code falls to the internal clock
    function automatic pmcs_src_t decode_select(input logic [1:0] sel);
        case (sel)
            `PMCS_SEL_PRI: decode_select = PMCS_SRC_PRI;
            `PMCS_SEL_SEC: decode_select = PMCS_SRC_SEC;
            `PMCS_SEL_RSV: decode_select = PMCS_SRC_INT;
            default:       decode_select = PMCS_SRC_INT;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Reset release through two flip-flops
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // Oscillator clocks sampled as levels; each must stay below half of core_clk
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            osc_meta <= 3'h0;
            osc_sync <= 3'h0;
            osc_prev <= 3'h0;
        end else begin
            osc_meta <= {internal_rc_clock, secondary_osc_clk, primary_osc_clk};
            osc_sync <= osc_meta;
            osc_prev <= osc_sync;
        end
    end

    // Oscillator stable flags from the analog side
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdy_meta <= 3'h0;
            rdy_sync <= 3'h0;
        end else begin
            rdy_meta <= osc_ready;
            rdy_sync <= rdy_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Requests to the sequencer
    assign req_src     = decode_select(clock_source_select);
    assign sw.tick     = osc_sync & ~osc_prev;
    assign sw.new_src  = req_src;
    assign sw.load     = !started;
    assign sw.load_src = two_speed_startup_en ? PMCS_SRC_INT : PMCS_SRC_PRI;
    // Switch only to a running source, one at a time, never on the way into Sleep
    assign sw.start    = started && !sw.busy && (mode == PMCS_RUN || mode == PMCS_IDLE)
                         && !take_sleep && (req_src != sw.active_src)
                         && rdy_sync[pmcs_src_index(req_src)];

    pmcs_switch_seq pmcs_switch_seq_inst (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .sw       (sw.seq)
    );

    // Two-speed start-up is taken once, on the first cycle after release
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            started <= 1'b0;
        end else begin
            started <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sleep instruction capture; a sleep during a switch waits for its end
    assign take_sleep = started && mode == PMCS_RUN && !sw.busy && (sleep_exec || sleep_pend);
    assign take_idle  = sleep_exec ? idle_on_sleep_select : pend_idle;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sleep_pend <= 1'b0;
            pend_idle  <= 1'b0;
        end else if (take_sleep) begin
            sleep_pend <= 1'b0;
        end else if (sleep_exec && mode == PMCS_RUN) begin
            sleep_pend <= 1'b1;
            pend_idle  <= idle_on_sleep_select;
        end
    end

    // Mode state machine
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode <= PMCS_RUN;
        end else begin
            case (mode)
                PMCS_RUN: begin
                    if (take_sleep) begin
                        mode <= take_idle ? PMCS_IDLE : PMCS_SLEEP;
                    end
                end
                PMCS_IDLE: begin
                    if (wake_event) begin
                        mode <= PMCS_RUN;
                    end
                end
                PMCS_SLEEP: begin
                    if (wake_event) begin
                        mode <= PMCS_WAKE;
                    end
                end
                PMCS_WAKE: begin
                    // Sources were stopped; resume only once the clock is stable
                    if (rdy_sync[pmcs_src_index(sw.active_src)]) begin
                        mode <= PMCS_RUN;
                    end
                end
                default: begin
                    mode <= PMCS_RUN;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Oscillator demand; old and new sources both run during a switch
    assign pending_target = sw.busy ? req_src : sw.active_src;
    assign pri_needed = (sw.active_src == PMCS_SRC_PRI) || (pending_target == PMCS_SRC_PRI);
    assign sec_needed = (sw.active_src == PMCS_SRC_SEC) || (pending_target == PMCS_SRC_SEC);
    assign int_needed = (sw.active_src == PMCS_SRC_INT) || (pending_target == PMCS_SRC_INT);

    // Clock enables; Sleep overrides the field, Wake restarts the active source
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cpu_clk_en       <= 1'b1;
            periph_clk_en    <= 1'b1;
            primary_osc_en   <= 1'b1;
            secondary_osc_en <= 1'b0;
            internal_osc_en  <= 1'b0;
        end else begin
            cpu_clk_en       <= (mode == PMCS_RUN);
            periph_clk_en    <= (mode == PMCS_RUN) || (mode == PMCS_IDLE);
            primary_osc_en   <= (mode != PMCS_SLEEP) && pri_needed;
            secondary_osc_en <= (mode != PMCS_SLEEP) && sec_needed;
            internal_osc_en  <= (mode != PMCS_SLEEP) && int_needed;
        end
    end

    // Status flags and device_clk_select follow the source actually in use
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            primary_clock_active_flag   <= 1'b1;
            secondary_clock_active_flag <= 1'b0;
            device_clk_select           <= `PMCS_RESET_SRC;
        end else begin
            primary_clock_active_flag   <= (sw.active_src == PMCS_SRC_PRI);
            secondary_clock_active_flag <= (sw.active_src == PMCS_SRC_SEC);
            device_clk_select           <= sw.active_src;
        end
    end

    // Control word as software would read it back
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            oscillator_control_reg <= `PMCS_CTRL_RESET;
        end else begin
            oscillator_control_reg                      <= 8'h00;
            oscillator_control_reg[`PMCS_IDLE_BIT]      <= idle_on_sleep_select;
            oscillator_control_reg[`PMCS_PRI_FLAG_BIT]  <= (sw.active_src == PMCS_SRC_PRI);
            oscillator_control_reg[`PMCS_SEL_HI:`PMCS_SEL_LO] <= clock_source_select;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sleep_entry_a: assert property (take_sleep && !take_idle |=> mode == PMCS_SLEEP)
        else $error("sleep instruction with idle bit low did not enter Sleep");
    idle_entry_a: assert property (take_sleep && take_idle |=> mode == PMCS_IDLE)
        else $error("sleep instruction with idle bit high did not enter Idle");
    no_spurious_a: assert property (mode == PMCS_RUN && !take_sleep |=> mode == PMCS_RUN)
        else $error("left Run without a sleep instruction");
    sleep_gating_a: assert property (mode == PMCS_SLEEP |=> !cpu_clk_en && !periph_clk_en
                                     && !primary_osc_en && !secondary_osc_en
                                     && !internal_osc_en)
        else $error("clock still running in Sleep");
    idle_gating_a: assert property (mode == PMCS_IDLE |=> !cpu_clk_en && periph_clk_en)
        else $error("Idle clocking wrong");
    run_gating_a: assert property (mode == PMCS_RUN |=> cpu_clk_en && periph_clk_en)
        else $error("Run clocking wrong");
    status_flags_a: assert property (started |=> primary_clock_active_flag
                                     == ($past(sw.active_src) == PMCS_SRC_PRI)
                                     && secondary_clock_active_flag
                                     == ($past(sw.active_src) == PMCS_SRC_SEC))
        else $error("status flags disagree with active source");
    sec_shutdown_a: assert property (sw.active_src == PMCS_SRC_SEC && !sw.busy
                                     |=> !primary_osc_en && secondary_clock_active_flag
                                     && !primary_clock_active_flag)
        else $error("primary not stopped on secondary");
    select_decode_a: assert property (clock_source_select == `PMCS_SEL_RSV
                                      |-> req_src == PMCS_SRC_INT)
        else $error("reserved code not mapped to internal clock");
    switch_start_a: assert property (sw.start |=> sw.busy)
        else $error("switch to running source did not start");
    reset_source_a: assert property (!started && !two_speed_startup_en
                                     |=> sw.active_src == PMCS_SRC_PRI
                                     && primary_clock_active_flag)
        else $error("reset did not start on primary");

    // Sleep held back by a switch, and its later hand-over
    sequence sleep_held;
        sleep_exec && mode == PMCS_RUN && !take_sleep;
    endsequence

    sequence held_taken;
        sleep_pend && !sleep_exec && take_sleep;
    endsequence

    // Full Sleep: mode first, every enable one edge later
    sequence sleep_taken;
        take_sleep && !take_idle;
    endsequence

    pend_capture_a: assert property (sleep_held |=> sleep_pend
                                     && pend_idle == $past(idle_on_sleep_select))
        else $error("held sleep lost its idle bit");
    held_entry_a: assert property (held_taken |=> (mode == PMCS_IDLE) == $past(pend_idle))
        else $error("held sleep entered the wrong mode");
    sleep_stops_a: assert property (sleep_taken |-> ##2 !cpu_clk_en && !periph_clk_en
                                    && !primary_osc_en && !secondary_osc_en
                                    && !internal_osc_en)
        else $error("Sleep left a clock running two edges after the instruction");
    flags_exclusive_a: assert property (!(primary_clock_active_flag
                                          && secondary_clock_active_flag))
        else $error("both source flags set");

endmodule

`default_nettype wire

/* dv/power_mode_clock_select_test.sv */
// Self-checking testbench for the power mode clock selector
`timescale 1ns/1ps
`default_nettype none

module power_mode_clock_select_test;
    import pmcs_pkg::*;

    logic        core_clk;
    logic        reset_n;
    logic        idle_on_sleep_select;
    logic [1:0]  clock_source_select;
    logic        sleep_exec;
    logic        wake_event;
    logic        two_speed_startup_en;
    logic        primary_osc_clk;
    logic        secondary_osc_clk;
    logic        internal_rc_clock;
    logic [2:0]  osc_ready;
    logic        cpu_clk_en;
    logic        periph_clk_en;
    logic        primary_osc_en;
    logic        secondary_osc_en;
    logic        internal_osc_en;
    logic [1:0]  device_clk_select;
    logic        primary_clock_active_flag;
    logic        secondary_clock_active_flag;
    logic [7:0]  oscillator_control_reg;
    int          error_cnt;
    int          n_compared;

    pmcs_power_mode_ctrl pmcs_power_mode_ctrl_inst (
        .core_clk                    (core_clk),
        .reset_n                     (reset_n),
        .idle_on_sleep_select        (idle_on_sleep_select),
        .clock_source_select         (clock_source_select),
        .sleep_exec                  (sleep_exec),
        .wake_event                  (wake_event),
        .two_speed_startup_en        (two_speed_startup_en),
        .primary_osc_clk             (primary_osc_clk),
        .secondary_osc_clk           (secondary_osc_clk),
        .internal_rc_clock           (internal_rc_clock),
        .osc_ready                   (osc_ready),
        .cpu_clk_en                  (cpu_clk_en),
        .periph_clk_en               (periph_clk_en),
        .primary_osc_en              (primary_osc_en),
        .secondary_osc_en            (secondary_osc_en),
        .internal_osc_en             (internal_osc_en),
        .device_clk_select           (device_clk_select),
        .primary_clock_active_flag   (primary_clock_active_flag),
        .secondary_clock_active_flag (secondary_clock_active_flag),
        .oscillator_control_reg      (oscillator_control_reg)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Core clock at 200 MHz
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // Oscillators: periods 40, 60 and 50 ns, all far below core_clk/2 so the syncs see them
    initial begin
        primary_osc_clk = 1'b0;
        forever #20 primary_osc_clk = ~primary_osc_clk;
    end
    initial begin
        secondary_osc_clk = 1'b0;
        forever #30 secondary_osc_clk = ~secondary_osc_clk;
    end
    initial begin
        internal_rc_clock = 1'b0;
        forever #25 internal_rc_clock = ~internal_rc_clock;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Inputs move on the falling edge only, away from the sampling edge
    task automatic tick(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    // Single-bit comparison
    task automatic check_bit(input string what, input logic exp, input logic got);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
        end
    endtask

    // Multi-bit comparison, narrower values are zero-extended by the caller
    task automatic check_vec(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Closing report, also reached when a bounded wait runs out
    task automatic print_verdict();
        $display("Counts: %0d compared, %0d mismatched", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end
        else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Bounded wait for the device clock code; a stall is a mismatch
    task automatic wait_select(input logic [1:0] code, output int cyc);
        cyc = 0;
        while (device_clk_select !== code && cyc < 300) begin
            tick(1);
            cyc++;
        end
        if (device_clk_select !== code) begin
            error_cnt++;
            $display("CHECK FAILED device_clk_select expected %h seen %h", code, device_clk_select);
            print_verdict();
        end
    endtask

    // Enables and flags expected for a given active source code
    task automatic check_source(input logic [1:0] sel, input logic cpu_on);
        check_bit("cpu_clk_en", cpu_on, cpu_clk_en);
        check_bit("periph_clk_en", 1'b1, periph_clk_en);
        check_bit("primary_osc_en", sel == 2'h0, primary_osc_en);
        check_bit("secondary_osc_en", sel == 2'h1, secondary_osc_en);
        check_bit("internal_osc_en", sel == 2'h3, internal_osc_en);
        check_bit("primary_flag", sel == 2'h0, primary_clock_active_flag);
        check_bit("secondary_flag", sel == 2'h1, secondary_clock_active_flag);
    endtask

    // Program the field, wait for the hand-over and time it against the minimum
    task automatic do_switch(input logic [1:0] code, input logic [1:0] exp_sel, input int min_cyc);
        int cyc;
        clock_source_select = code;
        wait_select(exp_sel, cyc);
        check_bit("switch not shorter than minimum", 1'b1, cyc >= min_cyc);
        tick(4);
        check_vec("device_clk_select", {6'h00, exp_sel}, {6'h00, device_clk_select});
        check_source(exp_sel, 1'b1);
        check_vec("oscillator_control_reg",
                  {idle_on_sleep_select, 3'h0, exp_sel == 2'h0, 1'b0, code},
                  oscillator_control_reg);
        $display("Test switch to code %b done", code);
    endtask

    // Sleep instruction with the idle bit as given, then a wake-up
    task automatic sleep_and_wake(input logic idle, input logic [1:0] sel);
        int cyc;
        idle_on_sleep_select = idle;
        sleep_exec = 1'b1;
        tick(1);
        sleep_exec = 1'b0;
        idle_on_sleep_select = ~idle;
        tick(2);
        check_bit("cpu_clk_en low power", 1'b0, cpu_clk_en);
        check_bit("periph_clk_en low power", idle, periph_clk_en);
        check_bit("primary_osc_en low power", idle && sel == 2'h0, primary_osc_en);
        check_bit("secondary_osc_en low power", idle && sel == 2'h1, secondary_osc_en);
        check_bit("internal_osc_en low power", idle && sel == 2'h3, internal_osc_en);
        tick(6);
        check_bit("cpu stays off without wake", 1'b0, cpu_clk_en);
        wake_event = 1'b1;
        tick(1);
        wake_event = 1'b0;
        cyc = 0;
        while (cpu_clk_en !== 1'b1 && cyc < 50) begin
            tick(1);
            cyc++;
        end
        if (cpu_clk_en !== 1'b1) begin
            error_cnt++;
            $display("CHECK FAILED cpu_clk_en after wake expected 1 seen %b", cpu_clk_en);
            print_verdict();
        end
        tick(2);
        check_source(sel, 1'b1);
        idle_on_sleep_select = 1'b0;
        $display("Test sleep with idle bit %b done", idle);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        int cyc;
        error_cnt = 0;
        n_compared = 0;
        reset_n = 1'b0;
        idle_on_sleep_select = 1'b0;
        clock_source_select = 2'h0;
        sleep_exec = 1'b0;
        wake_event = 1'b0;
        two_speed_startup_en = 1'b0;
        osc_ready = 3'h7;
        tick(4);
        reset_n = 1'b1;
        tick(8);
        // Reset state: primary run, primary flag up
        check_source(2'h0, 1'b1);
        check_vec("device_clk_select reset", 8'h00, {6'h00, device_clk_select});
        check_vec("oscillator_control_reg reset", 8'h08, oscillator_control_reg);
        $display("Test reset state done");
        // Primary 40 ns to secondary 60 ns: at least one old and two new periods
        do_switch(2'h1, 2'h1, 32);
        sleep_and_wake(1'b1, 2'h1);
        sleep_and_wake(1'b0, 2'h1);
        // Secondary to internal, then the unlisted code must not move it
        do_switch(2'h3, 2'h3, 32);
        do_switch(2'h2, 2'h3, 0);
        sleep_and_wake(1'b1, 2'h3);
        // Internal 50 ns back to primary 40 ns
        do_switch(2'h0, 2'h0, 26);
        sleep_and_wake(1'b0, 2'h0);
        // Second reset, two-speed: internal first, a sleep held over the switch to primary
        two_speed_startup_en = 1'b1;
        reset_n = 1'b0;
        tick(4);
        reset_n = 1'b1;
        tick(6);
        check_vec("device_clk_select two-speed", 8'h03, {6'h00, device_clk_select});
        idle_on_sleep_select = 1'b1;
        sleep_exec = 1'b1;
        tick(1);
        sleep_exec = 1'b0;
        idle_on_sleep_select = 1'b0;
        wait_select(2'h0, cyc);
        tick(3);
        check_source(2'h0, 1'b0);
        $display("Test two-speed reset and held sleep done");
        print_verdict();
    end
endmodule

`default_nettype wire
